// file: rtl/nvsc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_consts.svh"
// What this block does
// - host holds address stable across the whole write.
// - host keeps output enable high throughout every write.
// - six reads 000,555,2AA,7FF,0F0,70F start a save.
// - six reads 000,555,2AA,7FF,0F0,70E start a restore.
// - each sequence step is a read framed by chip enable low then high.
// - sequence steps are reads with write strobe high; output enable may stay high.
// - host must not hold a write state when the power-up restore ends.
module nvsc_host #(
  parameter int SAVE_CYC = (`NVSC_SAVE_MS * 1000000) / `NVSC_CLK_NS,
  parameter int RESTORE_CYC = (`NVSC_RESTORE_US * 1000) / `NVSC_CLK_NS,
  parameter int POWERUP_CYC = (`NVSC_POWERUP_US * 1000) / `NVSC_CLK_NS
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire nvsc_pkg::nvsc_op_t i_req_op,
  input wire logic [10:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic i_supply_ok,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_rdata,
  output logic o_chip_en_n,
  output logic o_out_en_n,
  output logic o_write_n,
  output logic [10:0] o_byte_select_lines,
  output logic [7:0] o_bidir_data_lines_o,
  output logic o_bidir_data_lines_oe,
  input wire logic [7:0] i_bidir_data_lines_i
);
  typedef enum logic [2:0] {
    NVSC_IDLE,
    NVSC_SETUP,
    NVSC_STROBE,
    NVSC_HOLD,
    NVSC_NEXT,
    NVSC_WAIT
  } nvsc_state_t;

  localparam int TW = 24;

  // sequence address for step index; step 5 depends on save or restore
  function automatic logic [10:0] nvsc_seq_addr(input logic [2:0] idx, input logic save);
    unique case (idx)
      3'h0: nvsc_seq_addr = `NVSC_SEQ_A0;
      3'h1: nvsc_seq_addr = `NVSC_SEQ_A1;
      3'h2: nvsc_seq_addr = `NVSC_SEQ_A2;
      3'h3: nvsc_seq_addr = `NVSC_SEQ_A3;
      3'h4: nvsc_seq_addr = `NVSC_SEQ_A4;
      default: nvsc_seq_addr = save ? `NVSC_SEQ_SAVE : `NVSC_SEQ_RESTORE;
    endcase
  endfunction

  nvsc_state_t state, next_state;
  nvsc_pkg::nvsc_op_t op, next_op;
  logic [2:0] step, next_step;
  logic [3:0] phase, next_phase;
  logic ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n;
  logic [10:0] addr, next_addr;
  logic [7:0] wdata, next_wdata, rdata, next_rdata;
  logic doe, next_doe, ready, next_ready, rsp, next_rsp;
  logic supply_meta, supply_sync, supply_prev;
  logic [7:0] data_meta, data_sync;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_busy, tmr_done;

  // two-stage sync of pin inputs
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
      supply_prev <= 1'b0;
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end else begin
      supply_meta <= i_supply_ok;
      supply_sync <= supply_meta;
      supply_prev <= supply_sync;
      data_meta <= i_bidir_data_lines_i;
      data_sync <= data_meta;
    end
  end

  nvsc_timer #(.WIDTH(TW)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // pin sequencer
  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_phase = phase;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_doe = doe;
    next_ready = 1'b0;
    next_rsp = 1'b0;
    tmr_load = 1'b0;
    tmr_count = '0;
    // supply rising means a power-up restore is running; wait it out
    if (supply_sync && !supply_prev) begin
      tmr_load = 1'b1;
      tmr_count = TW'(POWERUP_CYC);
    end
    unique case (state)
      NVSC_IDLE: begin
        // no request, so no write, while the power-up restore runs
        // load cycle blocked too, else ready pulses once before the timer is busy
        next_ready = supply_sync && !tmr_load && !tmr_busy;
        if (ready && i_req_valid) begin
          next_ready = 1'b0;
          next_op = i_req_op;
          next_step = 3'h0;
          next_wdata = i_req_wdata;
          next_phase = 4'(`NVSC_SETUP_CYC);
          next_state = NVSC_SETUP;
          // address set before the strobe and held through it
          next_addr = (i_req_op == nvsc_pkg::NVSC_OP_READ || i_req_op == nvsc_pkg::NVSC_OP_WRITE)
                      ? i_req_addr : `NVSC_SEQ_A0;
          // output enable stays high on writes
          next_oe_n = (i_req_op != nvsc_pkg::NVSC_OP_READ);
          next_doe = (i_req_op == nvsc_pkg::NVSC_OP_WRITE);
        end
      end
      NVSC_SETUP: begin
        next_phase = phase - 4'h1;
        if (phase == 4'h1) begin
          next_ce_n = 1'b0;
          // write strobe low only for writes
          // sequence steps keep write strobe high
          next_we_n = (op != nvsc_pkg::NVSC_OP_WRITE);
          next_phase = 4'(`NVSC_STROBE_CYC);
          next_state = NVSC_STROBE;
        end
      end
      NVSC_STROBE: begin
        next_phase = phase - 4'h1;
        if (phase == 4'h1) begin
          // capture read data before enables rise
          next_rdata = data_sync;
          // chip enable and write strobe rise together, ending the access
          next_ce_n = 1'b1;
          next_we_n = 1'b1;
          next_phase = 4'(`NVSC_HOLD_CYC);
          next_state = NVSC_HOLD;
        end
      end
      NVSC_HOLD: begin
        next_phase = phase - 4'h1;
        if (phase == 4'h1) begin
          next_oe_n = 1'b1;
          next_doe = 1'b0;
          next_state = NVSC_NEXT;
        end
      end
      NVSC_NEXT: begin
        // six back-to-back reads with nothing in between
        if ((op == nvsc_pkg::NVSC_OP_SAVE || op == nvsc_pkg::NVSC_OP_RESTORE) && step != 3'h5) begin
          next_step = step + 3'h1;
          next_addr = nvsc_seq_addr(step + 3'h1, op == nvsc_pkg::NVSC_OP_SAVE);
          next_phase = 4'(`NVSC_SETUP_CYC);
          next_state = NVSC_SETUP;
        end else if (op == nvsc_pkg::NVSC_OP_SAVE && supply_sync) begin
          // stay off the pins for the save duration
          tmr_load = 1'b1;
          tmr_count = TW'(SAVE_CYC);
          next_state = NVSC_WAIT;
        end else if (op == nvsc_pkg::NVSC_OP_RESTORE) begin
          tmr_load = 1'b1;
          tmr_count = TW'(RESTORE_CYC);
          next_state = NVSC_WAIT;
        end else begin
          // save below trip level does nothing, so no wait
          next_rsp = 1'b1;
          next_state = NVSC_IDLE;
        end
      end
      NVSC_WAIT: begin
        if (tmr_done) begin
          next_rsp = 1'b1;
          next_state = NVSC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= NVSC_IDLE;
      op <= nvsc_pkg::NVSC_OP_READ;
      step <= 3'h0;
      phase <= 4'h0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 11'h000;
      wdata <= 8'h00;
      rdata <= 8'h00;
      doe <= 1'b0;
      ready <= 1'b0;
      rsp <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      phase <= next_phase;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      doe <= next_doe;
      ready <= next_ready;
      rsp <= next_rsp;
    end
  end

  // all pins straight from flip-flops
  assign o_chip_en_n = ce_n;
  assign o_out_en_n = oe_n;
  assign o_write_n = we_n;
  assign o_byte_select_lines = addr;
  assign o_bidir_data_lines_o = wdata;
  assign o_bidir_data_lines_oe = doe;
  assign o_req_ready = ready;
  assign o_rsp_valid = rsp;
  assign o_rsp_rdata = rdata;
endmodule
`default_nettype wire

// file: rtl/nvsc_consts.svh
`ifndef NVSC_CONSTS_SVH
`define NVSC_CONSTS_SVH
// sequence addresses, 11 bits
`define NVSC_SEQ_A0 11'h000
`define NVSC_SEQ_A1 11'h555
`define NVSC_SEQ_A2 11'h2aa
`define NVSC_SEQ_A3 11'h7ff
`define NVSC_SEQ_A4 11'h0f0
`define NVSC_SEQ_SAVE 11'h70f
`define NVSC_SEQ_RESTORE 11'h70e
// clock period in ns
`define NVSC_CLK_NS 4
// durations in their own units
`define NVSC_SAVE_MS 10
`define NVSC_RESTORE_US 20
`define NVSC_POWERUP_US 550
// pin phase lengths in cycles (25 ns grade rounded up)
`define NVSC_SETUP_CYC 2
`define NVSC_STROBE_CYC 7
`define NVSC_HOLD_CYC 2
`endif

// file: rtl/nvsc_pkg.sv
package nvsc_pkg;
  typedef enum logic [1:0] {
    NVSC_OP_READ,
    NVSC_OP_WRITE,
    NVSC_OP_SAVE,
    NVSC_OP_RESTORE
  } nvsc_op_t;
endpackage

// file: rtl/nvsc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, done pulses when it reaches zero
module nvsc_timer #(
  parameter int WIDTH = 24
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_busy,
  output logic o_done
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic done;
  logic next_done;

  // count down from load value
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (i_load) begin
      next_count = i_count;
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done = (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign o_busy = (count != '0);
  assign o_done = done;
endmodule
`default_nettype wire

// file: verification/nvsc_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
// pin and handshake checks on the host controller
module nvsc_host_checker (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire nvsc_pkg::nvsc_op_t i_req_op,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic o_chip_en_n,
  input wire logic o_out_en_n,
  input wire logic o_write_n,
  input wire logic [10:0] o_byte_select_lines,
  input wire logic [7:0] o_bidir_data_lines_o,
  input wire logic o_bidir_data_lines_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_read_lat;
    i_req_valid && o_req_ready && i_req_op == nvsc_pkg::NVSC_OP_READ |-> ##[10:16] o_rsp_valid;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  property p_ce_pulse;
    $fell(o_chip_en_n) |-> !o_chip_en_n [*7] ##1 o_chip_en_n;
  endproperty
  a_ce_pulse: assert property (p_ce_pulse) else $error("chip enable frame wrong length");
  property p_write_oe;
    !o_write_n |-> o_out_en_n;
  endproperty
  a_write_oe: assert property (p_write_oe) else $error("output enable low in write");
  property p_write_addr;
    !o_write_n && !$past(o_write_n) |-> $stable(o_byte_select_lines);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("address moved in write");
  property p_write_data;
    !o_write_n && !$past(o_write_n) |-> $stable(o_bidir_data_lines_o) && o_bidir_data_lines_oe;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data not held");
  property p_read_float;
    !o_out_en_n |-> !o_bidir_data_lines_oe;
  endproperty
  a_read_float: assert property (p_read_float) else $error("host drives during read");
  property p_rsp_pulse;
    o_rsp_valid |=> !o_rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer longer than a cycle");
  property p_ready_drop;
    i_req_valid && o_req_ready |=> !o_req_ready && o_write_n;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready kept after request");
endmodule
bind nvsc_host nvsc_host_checker u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_req_valid(i_req_valid), .i_req_op(i_req_op), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
  .o_chip_en_n(o_chip_en_n), .o_out_en_n(o_out_en_n), .o_write_n(o_write_n),
  .o_byte_select_lines(o_byte_select_lines), .o_bidir_data_lines_o(o_bidir_data_lines_o),
  .o_bidir_data_lines_oe(o_bidir_data_lines_oe));
`default_nettype wire

// file: verification/nvsc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural nonvolatile sram on the far side
module nvsc_mem_model (
  input wire logic i_chip_en_n,
  input wire logic i_out_en_n,
  input wire logic i_write_n,
  input wire logic [10:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_supply_ok,
  output logic [7:0] o_data,
  output logic o_drive
);
  logic [7:0] sram [2048];
  logic [7:0] shadow [2048];
  logic [10:0] seq [5] = '{11'h000, 11'h555, 11'h2aa, 11'h7ff, 11'h0f0};
  logic [7:0] last_q = 8'h00;
  logic busy = 1'b1;
  logic wrote = 1'b0;
  int step = 0;
  wire wr_act = !i_chip_en_n && !i_write_n;
  // shadow preset to a known pattern
  initial begin
    for (int i = 0; i < 2048; i++) shadow[i] = i[7:0] ^ 8'h3c;
  end
  // drive only in an idle read, else inverse of last
  assign o_drive = !i_chip_en_n && !i_out_en_n && i_write_n && !busy;
  assign o_data = o_drive ? sram[i_addr] : ~last_q;
  always @(i_addr or o_drive) if (o_drive) last_q = sram[i_addr];
  always @(negedge wr_act) if (!busy) sram[i_addr] = i_data;
  always @(posedge wr_act) wrote = 1'b1;
  always @(posedge i_chip_en_n) begin
    if (wrote) begin
      wrote = 1'b0;
      step = 0;
    end else if (!busy) begin
      if (step == 5 && (i_addr == 11'h70f || i_addr == 11'h70e)) begin
        step = 0;
        busy = 1'b1;
        if (!i_addr[0]) begin
          #30 sram = '{default: 8'h00};
          sram = shadow;
        end else if (i_supply_ok) begin
          #60 shadow = sram;
        end
        busy = 1'b0;
      end else if (step < 5 && i_addr == seq[step]) step++;
      else step = (i_addr == 11'h000) ? 1 : 0;
    end
  end
  always @(negedge i_supply_ok) busy = 1'b1;
  always @(posedge i_supply_ok) begin
    #100 sram = shadow;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic valid = 1'b0;
  nvsc_pkg::nvsc_op_t op = nvsc_pkg::NVSC_OP_READ;
  logic [10:0] addr = 11'h000;
  logic [7:0] wdata = 8'h00;
  logic supply = 1'b0;
  wire logic ready, rsp, ce_n, oe_n, we_n, doe, mdrv;
  wire logic [10:0] a;
  wire logic [7:0] rdata, dout, mq, dq;
  int errors = 0;
  int total_checks = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  // resolved data wire
  assign dq = doe ? dout : mq;
  nvsc_host #(.SAVE_CYC(20), .RESTORE_CYC(10), .POWERUP_CYC(30)) dut (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_req_valid(valid), .i_req_op(op), .i_req_addr(addr), .i_req_wdata(wdata),
    .i_supply_ok(supply), .o_req_ready(ready), .o_rsp_valid(rsp), .o_rsp_rdata(rdata), .o_chip_en_n(ce_n),
    .o_out_en_n(oe_n), .o_write_n(we_n), .o_byte_select_lines(a), .o_bidir_data_lines_o(dout),
    .o_bidir_data_lines_oe(doe), .i_bidir_data_lines_i(dq));
  nvsc_mem_model mem (.i_chip_en_n(ce_n), .i_out_en_n(oe_n), .i_write_n(we_n), .i_addr(a), .i_data(dq),
    .i_supply_ok(supply), .o_data(mq), .o_drive(mdrv));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host and memory never drive the data wire together
  always @(posedge i_sys_clk) begin
    if (doe === 1'b1 && mdrv === 1'b1) begin
      errors++;
      $display("mismatch at %0t: data wire contention", $time);
    end
  end
  task automatic timeout();
    errors++;
    $display("mismatch at %0t: wait ran out", $time);
    give_verdict();
  endtask
  // one request, held until ready is sampled high, then waits for its answer
  task automatic req(input nvsc_pkg::nvsc_op_t o, input logic [10:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    valid <= 1'b1;
    op <= o;
    addr <= ad;
    wdata <= d;
    @(posedge i_sys_clk);
    while (ready !== 1'b1) begin
      n++;
      if (n > 3000) timeout();
      @(posedge i_sys_clk);
    end
    valid <= 1'b0;
    n = 0;
    while (rsp !== 1'b1) begin
      n++;
      if (n > 3000) timeout();
      @(posedge i_sys_clk);
    end
  endtask
  task automatic t_powerup();
    repeat (10) @(posedge i_sys_clk);
    chk({7'h00, ready}, 8'h00);
    supply <= 1'b1;
    req(nvsc_pkg::NVSC_OP_READ, 11'h005, 8'h00);
    chk(rdata, 8'h39);
    $display("test powerup done");
  endtask
  task automatic t_rw();
    req(nvsc_pkg::NVSC_OP_WRITE, 11'h7ff, 8'ha5);
    req(nvsc_pkg::NVSC_OP_WRITE, 11'h000, 8'h5a);
    req(nvsc_pkg::NVSC_OP_READ, 11'h7ff, 8'h00);
    chk(rdata, 8'ha5);
    req(nvsc_pkg::NVSC_OP_READ, 11'h000, 8'h00);
    chk(rdata, 8'h5a);
    $display("test read write done");
  endtask
  task automatic t_save_restore();
    req(nvsc_pkg::NVSC_OP_WRITE, 11'h003, 8'hc3);
    req(nvsc_pkg::NVSC_OP_SAVE, 11'h000, 8'h00);
    req(nvsc_pkg::NVSC_OP_WRITE, 11'h003, 8'h11);
    req(nvsc_pkg::NVSC_OP_READ, 11'h003, 8'h00);
    chk(rdata, 8'h11);
    req(nvsc_pkg::NVSC_OP_RESTORE, 11'h000, 8'h00);
    req(nvsc_pkg::NVSC_OP_READ, 11'h003, 8'h00);
    chk(rdata, 8'hc3);
    req(nvsc_pkg::NVSC_OP_READ, 11'h7ff, 8'h00);
    chk(rdata, 8'ha5);
    $display("test save restore done");
  endtask
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_powerup();
    t_rw();
    t_save_restore();
    give_verdict();
  end
endmodule
`default_nettype wire
